/* File: verilog/ssp_core.sv */
// Synchronous serial port core: divider, FIFOs, events, framing engine.
// Assumes all inputs are synchronous to clk; the port acts as link master.
// Contract
// (RULE_01) Prescale by even divisor 2 to 254
// (RULE_02) Further divide by one plus rate factor
// (RULE_03) Writes push into 16x8 transmit FIFO
// (RULE_04) Received words registered, then pushed; reads pop
// (RULE_05) Four events ORed into one request
// (RULE_06) Event reaches request only when mask set
// (RULE_07) Raw and masked event states readable
// (RULE_08) MSB first, 4 to 16 bit frames
// (RULE_09) Serial clock idle outside active transfers
// (RULE_10) Idle timeout flags data left in receive FIFO
// (RULE_11) SPI and message: select low whole frame
// (RULE_12) Pulse format: select pulse, drive rise, sample fall
// (RULE_13) Message: 8-bit control, wait, then reply
// (RULE_14) Pulse format idle: clock, select low, data released
// (RULE_15) Pulse format: select pulse loads word, MSB next
// (RULE_16) Pulse format: receive push on following rising edge
// (RULE_17) Polarity sets idle clock level
// (RULE_18) Phase selects first or second sampling edge
// (RULE_19) Idle: clock low, select high, data low
// (RULE_20) Select low, data half later, clock after
// (RULE_21) Select high one period after last sample
// (RULE_22) Select pulses high between back-to-back words; SPI phase 1 holds select low between words instead
// (RULE_23) Timeout is fixed count of idle half periods
`timescale 1ns/1ps
module ssp_core import ssp_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic master_mode,
  input wire logic [1:0] frame_format,
  input wire logic clock_polarity_setting,
  input wire logic clock_phase_setting,
  input wire logic [3:0] data_size,
  input wire logic [7:0] prescale_divisor,
  input wire logic [7:0] clock_rate_factor,
  input wire logic [3:0] event_mask,
  input wire logic overrun_clear,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  output logic wr_ready,
  input wire logic rd_pop,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic [3:0] raw_events,
  output logic [3:0] masked_events,
  output logic irq,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  output logic frame_select_pin,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic serial_data_in
);
  function automatic logic [15:0] size_mask(input logic [3:0] sz);
    size_mask = 16'hffff >> (SIZE_MAX - sz);
  endfunction
  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = p + 3'h1;
  endfunction

  // Bit rate divider
  logic [6:0] pre_cnt_ff, nxt_pre_cnt, psc_half;
  logic [7:0] rate_cnt_ff, nxt_rate_cnt;
  logic pre_tick, half_tick;
  always_comb begin
    psc_half = (prescale_divisor[7:1] == 7'h00) ? PSC_HALF_MIN : prescale_divisor[7:1]; // RULE_01
    pre_tick = (pre_cnt_ff >= psc_half - PSC_HALF_MIN);
    half_tick = pre_tick && (rate_cnt_ff >= clock_rate_factor); // RULE_02
    nxt_pre_cnt = pre_tick ? 7'h00 : pre_cnt_ff + 7'h01;
    nxt_rate_cnt = rate_cnt_ff;
    if (pre_tick) begin
      nxt_rate_cnt = half_tick ? 8'h00 : rate_cnt_ff + 8'h01;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_cnt_ff <= 7'h00;
      rate_cnt_ff <= 8'h00;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
      rate_cnt_ff <= nxt_rate_cnt;
    end
  end

  // FIFOs
  logic [15:0] tx_mem [FIFO_DEPTH];
  logic [15:0] rx_mem [FIFO_DEPTH];
  logic [2:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
  logic [3:0] tx_cnt_ff, rx_cnt_ff, nxt_tx_cnt, nxt_rx_cnt;
  logic tx_push, tx_pop, rx_push, rx_store, rx_take;
  logic [15:0] rx_word;
  always_comb begin
    wr_ready = (tx_cnt_ff != FIFO_FULL);
    tx_push = wr_valid && wr_ready; // RULE_03
    rd_valid = (rx_cnt_ff != 4'h0);
    rx_take = rd_pop && rd_valid; // RULE_04
    rx_store = rx_push && (rx_cnt_ff != FIFO_FULL);
    nxt_tx_cnt = tx_cnt_ff + {3'h0, tx_push} - {3'h0, tx_pop};
    nxt_rx_cnt = rx_cnt_ff + {3'h0, rx_store} - {3'h0, rx_take};
    rd_data = rx_mem[rx_rp_ff];
  end
  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= wr_data;
    end
    if (rx_store) begin
      rx_mem[rx_wp_ff] <= rx_word; // RULE_04
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_wp_ff <= 3'h0;
      tx_rp_ff <= 3'h0;
      rx_wp_ff <= 3'h0;
      rx_rp_ff <= 3'h0;
      tx_cnt_ff <= 4'h0;
      rx_cnt_ff <= 4'h0;
    end else begin
      tx_wp_ff <= tx_push ? ptr_inc(tx_wp_ff) : tx_wp_ff;
      tx_rp_ff <= tx_pop ? ptr_inc(tx_rp_ff) : tx_rp_ff;
      rx_wp_ff <= rx_store ? ptr_inc(rx_wp_ff) : rx_wp_ff;
      rx_rp_ff <= rx_take ? ptr_inc(rx_rp_ff) : rx_rp_ff;
      tx_cnt_ff <= nxt_tx_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
    end
  end

  // Framing engine
  ssp_state_e st_ff, nxt_st;
  logic [4:0] bitcnt_ff, nxt_bitcnt;
  logic [3:0] size_ff, nxt_size, load_size;
  logic [15:0] tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh, load_word;
  logic half_ff, nxt_half, seg_ff, nxt_seg;
  logic sclk_ff, nxt_sclk, fss_ff, nxt_fss, dout_ff, nxt_dout, doe_ff, nxt_doe;
  logic idle_lvl, act_lvl, samp_first, can_samp, more, is_pulse, is_spi, is_msg;
  always_comb begin
    is_pulse = (frame_format == FMT_PULSE);
    is_spi = (frame_format == FMT_SPI);
    is_msg = (frame_format == FMT_MSG);
    idle_lvl = is_spi && clock_polarity_setting; // RULE_17 RULE_19
    act_lvl = ~idle_lvl;
    samp_first = (is_spi && !clock_phase_setting) || is_msg; // RULE_18
    can_samp = !(is_msg && !seg_ff); // RULE_13
    more = enable && master_mode && (tx_cnt_ff != 4'h0);
    load_size = is_msg ? MSG_CTRL_SIZE : ((data_size < SIZE_MIN) ? SIZE_MIN : data_size);
    load_word = tx_mem[tx_rp_ff] << (SIZE_MAX - load_size); // RULE_08
    nxt_st = st_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_size = size_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_half = half_ff;
    nxt_seg = seg_ff;
    nxt_sclk = sclk_ff;
    nxt_fss = fss_ff;
    nxt_dout = tx_sh_ff[15];
    nxt_doe = !is_pulse || (st_ff != ST_IDLE); // RULE_14
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_word = rx_sh_ff & size_mask(size_ff);
    case (st_ff)
      ST_IDLE: begin
        nxt_sclk = idle_lvl; // RULE_09
        nxt_fss = !is_pulse; // RULE_14 RULE_19
        nxt_dout = 1'b0;
        if (half_tick && more) begin
          tx_pop = 1'b1;
          nxt_tx_sh = load_word; // RULE_15
          nxt_size = load_size;
          nxt_bitcnt = {1'b0, load_size};
          nxt_half = 1'b0;
          nxt_seg = 1'b0;
          nxt_st = ST_LEAD;
          nxt_fss = is_pulse; // RULE_11 RULE_15
          nxt_sclk = is_pulse ? 1'b1 : idle_lvl;
          nxt_doe = 1'b1;
        end
      end
      ST_LEAD: begin
        nxt_dout = is_pulse ? 1'b0 : (half_ff && tx_sh_ff[15]); // RULE_20
        if (half_tick) begin
          if (!half_ff) begin
            nxt_half = 1'b1;
            nxt_sclk = is_pulse ? 1'b0 : idle_lvl;
            nxt_dout = !is_pulse && tx_sh_ff[15]; // RULE_20
          end else begin
            nxt_half = 1'b0;
            nxt_st = ST_BITS;
            nxt_sclk = act_lvl; // RULE_12 RULE_20
            nxt_fss = is_pulse ? 1'b0 : fss_ff;
            if (samp_first) begin
              nxt_rx_sh = {rx_sh_ff[14:0], serial_data_in};
            end
          end
        end
      end
      ST_BITS: begin
        if (half_tick && !half_ff) begin
          nxt_half = 1'b1;
          nxt_sclk = idle_lvl;
          if (samp_first) begin
            nxt_tx_sh = (bitcnt_ff != 5'h00) ? tx_sh_ff << 1 : tx_sh_ff; // RULE_20
          end else begin
            nxt_rx_sh = {rx_sh_ff[14:0], serial_data_in}; // RULE_12 RULE_18
          end
        end else if (half_tick && bitcnt_ff != 5'h00) begin
          nxt_half = 1'b0;
          nxt_bitcnt = bitcnt_ff - 5'h01;
          nxt_sclk = act_lvl;
          if (samp_first && can_samp) begin
            nxt_rx_sh = {rx_sh_ff[14:0], serial_data_in}; // RULE_20
          end else if (!samp_first) begin
            nxt_tx_sh = tx_sh_ff << 1; // RULE_12
          end
        end else if (half_tick && is_msg && !seg_ff) begin
          // Reply phase; its first clock is the slave's wait cycle
          nxt_seg = 1'b1; // RULE_13
          nxt_half = 1'b0;
          nxt_size = (data_size < SIZE_MIN) ? SIZE_MIN : data_size;
          nxt_bitcnt = {1'b0, nxt_size} + 5'h01;
          nxt_tx_sh = 16'h0000;
          nxt_sclk = act_lvl;
        end else if (half_tick) begin
          rx_push = 1'b1; // RULE_04 RULE_16
          nxt_half = 1'b0;
          nxt_sclk = idle_lvl;
          if (is_pulse && more) begin
            tx_pop = 1'b1;
            nxt_tx_sh = load_word;
            nxt_size = load_size;
            nxt_bitcnt = {1'b0, load_size};
            nxt_st = ST_LEAD;
            nxt_fss = 1'b1; // RULE_15
            nxt_sclk = 1'b1;
          end else if (is_spi && clock_phase_setting && more) begin
            tx_pop = 1'b1;
            nxt_tx_sh = load_word;
            nxt_size = load_size;
            nxt_bitcnt = {1'b0, load_size};
            nxt_sclk = act_lvl;
          end else if (is_spi && clock_phase_setting) begin
            nxt_st = ST_TAIL;
          end else begin
            nxt_st = ST_IDLE;
            nxt_fss = !is_pulse; // RULE_21 RULE_22
          end
        end
      end
      ST_TAIL: begin
        if (half_tick) begin
          nxt_st = ST_IDLE;
          nxt_fss = 1'b1; // RULE_21
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    if (nxt_st == ST_BITS) begin
      nxt_dout = nxt_tx_sh[15]; // RULE_20 RULE_12
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= ST_IDLE;
      bitcnt_ff <= 5'h00;
      size_ff <= SIZE_MIN;
      tx_sh_ff <= 16'h0000;
      rx_sh_ff <= 16'h0000;
      half_ff <= 1'b0;
      seg_ff <= 1'b0;
      sclk_ff <= 1'b0;
      fss_ff <= 1'b0;
      dout_ff <= 1'b0;
      doe_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      bitcnt_ff <= nxt_bitcnt;
      size_ff <= nxt_size;
      tx_sh_ff <= nxt_tx_sh;
      rx_sh_ff <= nxt_rx_sh;
      half_ff <= nxt_half;
      seg_ff <= nxt_seg;
      sclk_ff <= nxt_sclk;
      fss_ff <= nxt_fss;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
    end
  end
  assign serial_clock_pin_o = sclk_ff;
  assign serial_clock_pin_oe = master_mode; // RULE_19
  assign frame_select_pin = fss_ff;
  assign serial_data_out = dout_ff;
  assign serial_data_out_oe = doe_ff;

  // Events
  logic [7:0] to_cnt_ff, nxt_to_cnt;
  logic [3:0] raw_ff, nxt_raw;
  always_comb begin
    nxt_to_cnt = to_cnt_ff;
    if (st_ff != ST_IDLE) begin
      nxt_to_cnt = 8'h00;
    end else if (half_tick && to_cnt_ff != RX_TIMEOUT_HALVES) begin
      nxt_to_cnt = to_cnt_ff + 8'h01; // RULE_23
    end
    nxt_raw[EV_TX] = (nxt_tx_cnt <= TX_SVC_LEVEL);
    nxt_raw[EV_RX] = (nxt_rx_cnt >= RX_SVC_LEVEL);
    nxt_raw[EV_RT] = (to_cnt_ff == RX_TIMEOUT_HALVES) && (rx_cnt_ff != 4'h0); // RULE_10
    nxt_raw[EV_RO] = (rx_push && !rx_store) || (raw_ff[EV_RO] && !overrun_clear);
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      to_cnt_ff <= 8'h00;
      raw_ff <= 4'h1;
    end else begin
      to_cnt_ff <= nxt_to_cnt;
      raw_ff <= nxt_raw;
    end
  end
  assign raw_events = raw_ff; // RULE_07
  assign masked_events = raw_ff & event_mask; // RULE_06 RULE_07
  assign irq = |masked_events; // RULE_05

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_mask_gates: assert property (event_mask == 4'h0 |-> !irq) // RULE_06
    else $error("irq with all events masked");
  a_tx_push_count: assert property (tx_push && !tx_pop |=> tx_cnt_ff == $past(tx_cnt_ff) + 4'h1) // RULE_03
    else $error("tx count did not grow");
  a_rx_pop_count: assert property (rx_take && !rx_store |=> rx_cnt_ff == $past(rx_cnt_ff) - 4'h1) // RULE_04
    else $error("rx count did not shrink");
  a_idle_clock_level: assert property ((st_ff == ST_IDLE && $stable(frame_format) // RULE_09
    && $stable(clock_polarity_setting))[*2] |-> serial_clock_pin_o == idle_lvl)
    else $error("idle clock level wrong");
  a_frame_select_low: assert property (st_ff == ST_BITS && !is_pulse |-> !frame_select_pin) // RULE_11
    else $error("select high inside frame");
  a_pulse_idle_pins: assert property ((st_ff == ST_IDLE && is_pulse)[*2] // RULE_14
    |-> !serial_data_out_oe && !frame_select_pin && !serial_clock_pin_o)
    else $error("pulse format idle pins wrong");
  a_overrun_sets: assert property (rx_push && rx_cnt_ff == FIFO_FULL ##1 !overrun_clear // RULE_05
    |-> raw_events[EV_RO] ##1 raw_events[EV_RO])
    else $error("overrun not sticky");
  a_timeout_sets: assert property (to_cnt_ff == RX_TIMEOUT_HALVES && rd_valid && !rd_pop // RULE_10
    |=> raw_events[EV_RT])
    else $error("timeout event missing");
  c_pulse_word: cover property (rx_push && is_pulse);
  c_spi_word: cover property (rx_push && is_spi && clock_phase_setting);
  c_msg_reply: cover property (rx_push && is_msg);
  c_overrun: cover property (rx_push && !rx_store);
endmodule // ssp_core

/* File: verilog/ssp_pkg.sv */
// Package for the synchronous serial port core.
// Assumes one system clock; all widths and levels are fixed here.
package ssp_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] FIFO_FULL = 4'h8;
  localparam logic [CNT_W-1:0] TX_SVC_LEVEL = 4'h4;
  localparam logic [CNT_W-1:0] RX_SVC_LEVEL = 4'h4;
  // Formats
  localparam logic [1:0] FMT_PULSE = 2'h0;
  localparam logic [1:0] FMT_SPI = 2'h1;
  localparam logic [1:0] FMT_MSG = 2'h2;
  // Frame sizes, as bit count minus one
  localparam logic [3:0] SIZE_MIN = 4'h3;
  localparam logic [3:0] SIZE_MAX = 4'hf;
  localparam logic [3:0] MSG_CTRL_SIZE = 4'h7;
  // Divider limits
  localparam logic [6:0] PSC_HALF_MIN = 7'h01;
  // Idle half periods before the receive timeout
  localparam logic [7:0] RX_TIMEOUT_HALVES = 8'h40;
  // Event bit positions
  localparam int EV_TX = 0;
  localparam int EV_RX = 1;
  localparam int EV_RT = 2;
  localparam int EV_RO = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_BITS = 3'b010,
    ST_TAIL = 3'b011
  } ssp_state_e;
endpackage

/* File: bench/ssp_slave_model.sv */
// Behavioural serial peripheral on the far side of the port, clock mode 0.
// Assumes the core is link master; select low frames each word.
`timescale 1ns/1ps
module ssp_slave_model (
  input wire logic sclk,
  input wire logic select,
  input wire logic mosi,
  output logic miso,
  output int frames
);
  logic [15:0] got[$];
  logic [15:0] sh_out;
  logic [15:0] sh_in;
  logic last;
  int nbits;
  initial begin
    miso = 1'b0;
    frames = 0;
    last = 1'b0;
    nbits = 0;
  end
  // Reply presented as soon as select falls
  always @(negedge select) begin
    sh_out = {8'hc3 ^ frames[7:0], 8'h00};
    sh_in = 16'h0000;
    nbits = 0;
    miso = sh_out[15];
    last = miso;
  end
  // Sample on rising edge, MSB first
  always @(posedge sclk) begin
    if (!select) begin
      sh_in = {sh_in[14:0], mosi};
      nbits++;
    end
  end
  // Change on falling edge
  always @(negedge sclk) begin
    if (!select) begin
      sh_out = sh_out << 1;
      miso = sh_out[15];
      last = miso;
    end
  end
  // Word ends on select rise; line driven to the inverse of the last bit
  always @(posedge select) begin
    if (nbits != 0) begin
      got.push_back(sh_in);
      frames++;
    end
    nbits = 0;
    miso = ~last;
  end
endmodule // ssp_slave_model

/* File: bench/test_ssp_core.sv */
// Self-checking bench for the serial port core in SPI mode 0 as master, then pulse-format idle levels with master_mode low.
// Assumes the slave model above sits on the serial pins.
`timescale 1ns/1ps
module test_ssp_core import ssp_pkg::*; ;
  logic clk, reset, enable, master_mode, pol, pha, overrun_clear, wr_valid, rd_pop;
  logic [1:0] frame_format;
  logic [3:0] data_size, event_mask;
  logic [7:0] prescale_divisor, clock_rate_factor;
  logic [15:0] wr_data, rd_data;
  logic wr_ready, rd_valid, irq, sclk_o, sclk_oe, fsel, sdo, sdo_oe, sdi, sclk;
  logic [3:0] raw_events, masked_events;
  int err_count, compares, cycles, frames;
  realtime t_prev, t_last;
  assign sclk = sclk_oe ? sclk_o : 1'b0;
  ssp_core DUT (.clk(clk), .reset(reset), .enable(enable), .master_mode(master_mode),
    .frame_format(frame_format), .clock_polarity_setting(pol), .clock_phase_setting(pha),
    .data_size(data_size), .prescale_divisor(prescale_divisor), .clock_rate_factor(clock_rate_factor),
    .event_mask(event_mask), .overrun_clear(overrun_clear), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_pop(rd_pop), .rd_valid(rd_valid), .rd_data(rd_data),
    .raw_events(raw_events), .masked_events(masked_events), .irq(irq),
    .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe), .frame_select_pin(fsel),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .serial_data_in(sdi));
  ssp_slave_model slave (.sclk(sclk), .select(fsel), .mosi(sdo), .miso(sdi), .frames(frames));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge sclk) begin
    t_prev = t_last;
    t_last = $realtime;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic write_word(input logic [15:0] d);
    for (int i = 0; i < 2000 && wr_ready !== 1'b1; i++) @(negedge clk);
    wr_valid = 1'b1;
    wr_data = d;
    @(negedge clk);
    wr_valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic read_word(input logic [15:0] exp);
    for (int i = 0; i < 2000 && rd_valid !== 1'b1; i++) @(negedge clk);
    check(rd_data, exp);
    rd_pop = 1'b1;
    @(negedge clk);
    rd_pop = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 5000 && frames < n; i++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask
  initial begin
    err_count = 0;
    compares = 0;
    cycles = 0;
    t_prev = 0;
    t_last = 0;
    reset = 1'b1;
    enable = 1'b0;
    master_mode = 1'b1;
    frame_format = FMT_SPI;
    pol = 1'b0;
    pha = 1'b0;
    data_size = 4'h7;
    prescale_divisor = 8'h02;
    clock_rate_factor = 8'h00;
    event_mask = 4'h0;
    overrun_clear = 1'b0;
    wr_valid = 1'b0;
    rd_pop = 1'b0;
    wr_data = 16'h0000;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check({13'h0000, sclk_o, fsel, sdo}, 16'h0002);
    check({12'h000, raw_events}, 16'h0001);
    check({15'h0000, irq}, 16'h0000);
    check({15'h0000, sclk_oe}, 16'h0001);
    // Fill the transmit queue while stopped
    for (int i = 0; i < 8; i++) write_word({8'hee, 8'h81 ^ 8'(i)});
    check({15'h0000, wr_ready}, 16'h0000);
    check({15'h0000, raw_events[EV_TX]}, 16'h0000);
    check({15'h0000, fsel}, 16'h0001);
    enable = 1'b1;
    wait_frames(8);
    check(16'(frames), 16'h0008);
    for (int i = 0; i < 8; i++) check(slave.got[i], {8'h00, 8'h81 ^ 8'(i)});
    check({12'h000, raw_events}, 16'h0003);
    repeat (80) @(negedge clk);
    check({15'h0000, raw_events[EV_RT]}, 16'h0001);
    event_mask = 4'h4;
    @(negedge clk);
    check({11'h000, irq, masked_events}, 16'h0014);
    event_mask = 4'h0;
    @(negedge clk);
    check({11'h000, irq, masked_events}, 16'h0000);
    // Ninth word meets a full receive queue
    write_word(16'h0042);
    wait_frames(9);
    check({15'h0000, raw_events[EV_RO]}, 16'h0001);
    event_mask = 4'h8;
    @(negedge clk);
    check({15'h0000, irq}, 16'h0001);
    overrun_clear = 1'b1;
    @(negedge clk);
    overrun_clear = 1'b0;
    @(negedge clk);
    check({15'h0000, raw_events[EV_RO]}, 16'h0000);
    for (int i = 0; i < 8; i++) read_word({8'h00, 8'hc3 ^ 8'(i)});
    @(negedge clk);
    check({14'h0000, rd_valid, raw_events[EV_RT]}, 16'h0000);
    // Slower divider, longest and shortest frames
    prescale_divisor = 8'h04;
    clock_rate_factor = 8'h02;
    data_size = SIZE_MAX;
    write_word(16'h8001);
    wait_frames(10);
    check(slave.got[9], 16'h8001);
    check(16'(int'((t_last - t_prev) / 4.0)), 16'h000c);
    data_size = SIZE_MIN;
    write_word(16'hfffa);
    wait_frames(11);
    check(slave.got[10], 16'h000a);
    read_word(16'hca00);
    read_word(16'h000c);
    // Pulse-framed idle levels
    enable = 1'b0;
    frame_format = FMT_PULSE;
    master_mode = 1'b0;
    repeat (4) @(negedge clk);
    check({13'h0000, sclk_o, fsel, sdo_oe}, 16'h0000);
    check({15'h0000, sclk_oe}, 16'h0000);
    end_of_test();
  end
endmodule // test_ssp_core
